// ### verilog/rtdn_pkg.sv
// Constants shared by the temporal denoise filter and its register slave
package rtdn_pkg;
  // Register bus geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 9'h000;
  localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 9'h004;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 9'h00C;
  localparam logic [ADDR_W-1:0] OFS_REVISION = 9'h010;
  localparam logic [ADDR_W-1:0] OFS_PIC_DIM = 9'h100;
  localparam logic [ADDR_W-1:0] OFS_CURVE_DATA = 9'h104;
  localparam logic [ADDR_W-1:0] OFS_BANK_IN_USE = 9'h108;
  localparam logic [ADDR_W-1:0] OFS_BANK_TARGET = 9'h10C;
  // Control word and event flag fields
  localparam int CTL_SOFT_ENABLE = 0;
  localparam int CTL_REG_COMMIT = 1;
  localparam int CTL_FILTER_BYPASS = 2;
  localparam int CTL_SOFT_RESET = 31;
  localparam int FLG_CURVE_LOAD_COMPLETE = 0;
  // Picture dimension fields
  localparam int DIM_W = 13;
  localparam int DIM_PIX_LSB = 0;
  localparam int DIM_LINE_LSB = 16;
  // Revision word, value arbitrary
  localparam logic [DATA_W-1:0] CORE_REVISION = 32'h0001_0000;
  // Motion transfer curve storage
  localparam int CURVE_BANKS = 8;
  localparam int BANK_W = 3;
  localparam int CURVE_LEN = 128;
  localparam int CURVE_HALF = 64;
  localparam int IDX_W = 7;
  localparam int MOTION_IDX_W = 6;
  // Video sample layout
  localparam int SAMPLE_W = 8;
  localparam int PIX_W = 16;
  // Fixed-point blend
  localparam int FRAC_SHIFT = 8;
  localparam int ROUND_HALF = 128;
  // Event vector positions
  localparam int EVT_CUR_EOL = 0;
  localparam int EVT_CUR_SOF = 2;
  localparam int EVT_PREV_EOL = 4;
  localparam int EVT_PREV_SOF = 6;
  // Output buffer depth
  localparam int OUT_FIFO_DEPTH = 4;
endpackage

// ### verilog/rtdn_core.sv
// Temporal denoise filter: register slave, curve store, datapath, output buffer
`timescale 1ns/10ps

module rtdn_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data,
  output logic [$clog2(DEPTH+1)-1:0] o_level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic push;
  logic pop;

  generate
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
      $error("rtdn_fifo needs DEPTH >= 2 and WIDTH >= 1");
    end
  endgenerate

  // Honest flags from the fill level
  assign o_ready = (o_level != ($clog2(DEPTH+1))'(DEPTH));
  assign o_valid = (o_level != '0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  // Storage, no reset needed on data
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_data;
  end

  // Pointers and level
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_level <= '0;
    end
    else if (i_clr)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      o_level <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        o_level <= o_level + 1'b1;
      else if (pop && !push)
        o_level <= o_level - 1'b1;
    end
  end
endmodule

module rtdn_core #(
  parameter logic [12:0] DEF_PIXELS = 13'd1920,
  parameter logic [12:0] DEF_LINES = 13'd1080,
  parameter logic [2:0] DEF_BANK = 3'd0
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [rtdn_pkg::ADDR_W-1:0] I_S_AXI_AWADDR,
  input wire logic I_S_AXI_AWVALID,
  output logic O_S_AXI_AWREADY,
  input wire logic [rtdn_pkg::DATA_W-1:0] I_S_AXI_WDATA,
  input wire logic [3:0] I_S_AXI_WSTRB,
  input wire logic I_S_AXI_WVALID,
  output logic O_S_AXI_WREADY,
  output logic [1:0] O_S_AXI_BRESP,
  output logic O_S_AXI_BVALID,
  input wire logic I_S_AXI_BREADY,
  input wire logic [rtdn_pkg::ADDR_W-1:0] I_S_AXI_ARADDR,
  input wire logic I_S_AXI_ARVALID,
  output logic O_S_AXI_ARREADY,
  output logic [rtdn_pkg::DATA_W-1:0] O_S_AXI_RDATA,
  output logic [1:0] O_S_AXI_RRESP,
  output logic O_S_AXI_RVALID,
  input wire logic I_S_AXI_RREADY,
  input wire logic [rtdn_pkg::PIX_W-1:0] I_CUR_DATA,
  input wire logic I_CUR_VALID,
  input wire logic I_CUR_LAST,
  input wire logic I_CUR_SOF,
  output logic O_CUR_READY,
  input wire logic [rtdn_pkg::PIX_W-1:0] I_PREV_DATA,
  input wire logic I_PREV_VALID,
  input wire logic I_PREV_LAST,
  input wire logic I_PREV_SOF,
  output logic O_PREV_READY,
  output logic [rtdn_pkg::PIX_W-1:0] O_OUT_DATA,
  output logic [rtdn_pkg::PIX_W-1:0] O_OUT_MOTION,
  output logic O_OUT_LAST,
  output logic O_OUT_SOF,
  output logic O_OUT_VALID,
  input wire logic I_OUT_READY,
  output logic O_IRQ,
  output logic [7:0] O_EVENT_VEC
);
  import rtdn_pkg::*;
  localparam int FW = 2 * PIX_W + 2;

  logic [31:0] ctrl;
  logic [31:0] flags;
  logic [31:0] mask;
  logic [31:0] dim_pend;
  logic [31:0] dim_act;
  logic [BANK_W-1:0] bank_pend;
  logic [BANK_W-1:0] bank_act;
  logic [BANK_W-1:0] bank_tgt;
  logic [IDX_W:0] load_idx;
  logic [7:0] curve_mem [0:CURVE_BANKS*CURVE_LEN-1];
  logic srst;
  logic wr_fire;
  logic rd_fire;
  logic load_done;
  logic acc;
  logic frame_end;
  logic [DIM_W-1:0] pix_cnt;
  logic [DIM_W-1:0] line_cnt;
  logic [PIX_W-1:0] blend;
  logic [PIX_W-1:0] motion;
  logic [FW-1:0] fifo_in;
  logic [FW-1:0] fifo_out;
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [2:0] fifo_level;
  logic at_sof_pos;
  logic at_eol_pos;

  generate
    if (DEF_PIXELS < 13'd32 || DEF_LINES < 13'd32)
    begin : g_bad_dim
      $error("rtdn_core default picture must be at least 32x32");
    end
  endgenerate

  // Soft reset acts immediately, whatever the stream position
  assign srst = ctrl[CTL_SOFT_RESET];
  assign wr_fire = O_S_AXI_AWREADY;
  assign rd_fire = O_S_AXI_ARREADY;

  // Merge write data under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
      if (be[b])
        res[8*b +: 8] = nw[8*b +: 8];
    return res;
  endfunction

  // Write channel: take address and data together, one response at a time
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_S_AXI_AWREADY <= 1'b0;
      O_S_AXI_WREADY <= 1'b0;
      O_S_AXI_BVALID <= 1'b0;
      O_S_AXI_BRESP <= 2'h0;
    end
    else
    begin
      O_S_AXI_AWREADY <= I_S_AXI_AWVALID && I_S_AXI_WVALID && !O_S_AXI_AWREADY
                         && !O_S_AXI_BVALID;
      O_S_AXI_WREADY <= I_S_AXI_AWVALID && I_S_AXI_WVALID && !O_S_AXI_AWREADY
                        && !O_S_AXI_BVALID;
      if (wr_fire)
        O_S_AXI_BVALID <= 1'b1;
      else if (I_S_AXI_BREADY)
        O_S_AXI_BVALID <= 1'b0;
      O_S_AXI_BRESP <= 2'h0;
    end
  end

  // Read channel; unmapped offsets answer zero with OKAY
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_S_AXI_ARREADY <= 1'b0;
      O_S_AXI_RVALID <= 1'b0;
      O_S_AXI_RDATA <= 32'h0000_0000;
      O_S_AXI_RRESP <= 2'h0;
    end
    else
    begin
      O_S_AXI_ARREADY <= I_S_AXI_ARVALID && !O_S_AXI_ARREADY && !O_S_AXI_RVALID;
      O_S_AXI_RRESP <= 2'h0;
      if (rd_fire)
      begin
        O_S_AXI_RVALID <= 1'b1;
        case (I_S_AXI_ARADDR)
          OFS_CONTROL: O_S_AXI_RDATA <= ctrl;
          OFS_EVENT_FLAGS: O_S_AXI_RDATA <= flags;
          OFS_IRQ_MASK: O_S_AXI_RDATA <= mask;
          OFS_REVISION: O_S_AXI_RDATA <= CORE_REVISION;
          OFS_PIC_DIM: O_S_AXI_RDATA <= dim_pend;
          OFS_BANK_IN_USE: O_S_AXI_RDATA <= {29'h0, bank_pend};
          OFS_BANK_TARGET: O_S_AXI_RDATA <= {29'h0, bank_tgt};
          default: O_S_AXI_RDATA <= 32'h0000_0000;
        endcase
      end
      else if (I_S_AXI_RREADY)
        O_S_AXI_RVALID <= 1'b0;
    end
  end

  // Control word stays writable during soft reset so software can release it
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      ctrl <= 32'h0000_0000;
    else if (wr_fire && I_S_AXI_AWADDR == OFS_CONTROL)
      ctrl <= merge(ctrl, I_S_AXI_WDATA, I_S_AXI_WSTRB) & 32'h8000_0007;
  end

  // Pending registers, mask and bank target; revision writes fall through
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      mask <= 32'h0000_0000;
      dim_pend <= {3'h0, DEF_LINES, 3'h0, DEF_PIXELS};
      bank_pend <= DEF_BANK;
      bank_tgt <= 3'h0;
    end
    else if (srst)
    begin
      mask <= 32'h0000_0000;
      dim_pend <= {3'h0, DEF_LINES, 3'h0, DEF_PIXELS};
      bank_pend <= DEF_BANK;
      bank_tgt <= 3'h0;
    end
    else if (wr_fire)
    begin
      case (I_S_AXI_AWADDR)
        OFS_IRQ_MASK: mask <= merge(mask, I_S_AXI_WDATA, I_S_AXI_WSTRB);
        OFS_PIC_DIM: dim_pend <= merge(dim_pend, I_S_AXI_WDATA, I_S_AXI_WSTRB)
                                 & 32'h1FFF_1FFF;
        OFS_BANK_IN_USE: bank_pend <= I_S_AXI_WDATA[BANK_W-1:0];
        OFS_BANK_TARGET: bank_tgt <= I_S_AXI_WDATA[BANK_W-1:0];
        default: mask <= mask;
      endcase
    end
  end

  // Curve loader: sequential index, restarted by any target write
  assign load_done = wr_fire && I_S_AXI_AWADDR == OFS_CURVE_DATA
                     && load_idx == (IDX_W+1)'(CURVE_LEN-1);
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      load_idx <= '0;
    else if (srst)
      load_idx <= '0;
    else if (wr_fire && I_S_AXI_AWADDR == OFS_BANK_TARGET)
      load_idx <= '0;
    else if (wr_fire && I_S_AXI_AWADDR == OFS_CURVE_DATA && !load_idx[IDX_W])
      load_idx <= load_idx + 1'b1;
  end

  // Curve banks; values beyond the 128th are dropped until restarted
  always_ff @(posedge I_CLK_SYS)
  begin
    if (wr_fire && I_S_AXI_AWADDR == OFS_CURVE_DATA && !load_idx[IDX_W])
      curve_mem[{bank_tgt, load_idx[IDX_W-1:0]}] <= I_S_AXI_WDATA[7:0];
  end

  // Sticky flags; a new event wins over a same-cycle clear
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      flags <= 32'h0000_0000;
    else if (srst)
      flags <= 32'h0000_0000;
    else
    begin
      if (wr_fire && I_S_AXI_AWADDR == OFS_EVENT_FLAGS)
        flags <= flags & ~(I_S_AXI_WDATA & {{8{I_S_AXI_WSTRB[3]}}, {8{I_S_AXI_WSTRB[2]}},
                 {8{I_S_AXI_WSTRB[1]}}, {8{I_S_AXI_WSTRB[0]}}});
      if (load_done)
        flags[FLG_CURVE_LOAD_COMPLETE] <= 1'b1;
    end
  end

  // Level interrupt, present since the register slave is always built
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_IRQ <= 1'b0;
    else
      O_IRQ <= |(flags & mask);
  end

  // Both streams are taken together; ready waits a cycle to see both valid
  assign acc = O_CUR_READY && I_CUR_VALID && I_PREV_VALID;
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_CUR_READY <= 1'b0;
      O_PREV_READY <= 1'b0;
    end
    else
    begin
      O_CUR_READY <= ctrl[CTL_SOFT_ENABLE] && !srst && I_CUR_VALID && I_PREV_VALID
                     && !acc && fifo_level <= 3'(OUT_FIFO_DEPTH-2);
      O_PREV_READY <= ctrl[CTL_SOFT_ENABLE] && !srst && I_CUR_VALID && I_PREV_VALID
                      && !acc && fifo_level <= 3'(OUT_FIFO_DEPTH-2);
    end
  end

  // Position tracking against the working geometry
  assign at_sof_pos = pix_cnt == '0 && line_cnt == '0;
  assign at_eol_pos = pix_cnt == dim_act[DIM_PIX_LSB +: DIM_W] - 1'b1;
  assign frame_end = acc && at_eol_pos
                     && line_cnt == dim_act[DIM_LINE_LSB +: DIM_W] - 1'b1;
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      pix_cnt <= '0;
      line_cnt <= '0;
    end
    else if (srst)
    begin
      pix_cnt <= '0;
      line_cnt <= '0;
    end
    else if (acc)
    begin
      if (I_CUR_SOF)
        pix_cnt <= DIM_W'(1); // Resync on the marker
      else if (at_eol_pos)
        pix_cnt <= '0;
      else
        pix_cnt <= pix_cnt + 1'b1;
      if (I_CUR_SOF)
        line_cnt <= '0;
      else if (frame_end)
        line_cnt <= '0;
      else if (at_eol_pos)
        line_cnt <= line_cnt + 1'b1;
    end
  end

  // Unlatched error vector; odd bits stay low
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
      O_EVENT_VEC <= 8'h00;
    else if (srst)
      O_EVENT_VEC <= 8'h00;
    else
    begin
      O_EVENT_VEC <= 8'h00;
      O_EVENT_VEC[EVT_CUR_EOL] <= acc && I_CUR_LAST && !at_eol_pos;
      O_EVENT_VEC[EVT_CUR_SOF] <= acc && I_CUR_SOF && !at_sof_pos;
      O_EVENT_VEC[EVT_PREV_EOL] <= acc && I_PREV_LAST && !at_eol_pos;
      O_EVENT_VEC[EVT_PREV_SOF] <= acc && I_PREV_SOF && !at_sof_pos;
    end
  end

  // Working set copied all at once at frame end, only when commit is set
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      dim_act <= {3'h0, DEF_LINES, 3'h0, DEF_PIXELS};
      bank_act <= DEF_BANK;
    end
    else if (srst)
    begin
      dim_act <= {3'h0, DEF_LINES, 3'h0, DEF_PIXELS};
      bank_act <= DEF_BANK;
    end
    else if (frame_end && ctrl[CTL_REG_COMMIT])
    begin
      dim_act <= dim_pend;
      bank_act <= bank_pend;
    end
  end

  // One engine per component: luma uses neighbours, chroma same-colour ones
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_eng
      localparam int STEP = (ch == 0) ? 1 : 2;
      logic [7:0] cur;
      logic [7:0] prv;
      logic [7:0] adiff;
      logic [7:0] hist [0:3];
      logic [9:0] fir;
      logic [7:0] k;
      logic signed [8:0] sdiff;
      logic signed [18:0] prod;
      logic signed [10:0] sum;
      assign cur = I_CUR_DATA[ch*SAMPLE_W +: SAMPLE_W];
      assign prv = I_PREV_DATA[ch*SAMPLE_W +: SAMPLE_W];
      assign adiff = (prv > cur) ? prv - cur : cur - prv;
      assign fir = 10'(adiff) + {1'b0, hist[STEP-1], 1'b0} + 10'(hist[2*STEP-1]);
      assign k = curve_mem[{bank_act, 1'(ch), fir[9:10-MOTION_IDX_W]}];
      assign sdiff = $signed({1'b0, prv}) - $signed({1'b0, cur});
      assign prod = sdiff * $signed({2'b00, k}) + 19'(ROUND_HALF);
      assign sum = $signed({3'b000, cur}) + 11'(prod >>> FRAC_SHIFT);
      assign motion[ch*SAMPLE_W +: SAMPLE_W] = fir[9:2];
      // Clip to a byte; bypass passes the current pixel untouched
      assign blend[ch*SAMPLE_W +: SAMPLE_W] = ctrl[CTL_FILTER_BYPASS] ? cur :
        (sum < 0) ? 8'h00 : (sum > 11'sd255) ? 8'hFF : sum[7:0];
      always_ff @(posedge I_CLK_SYS or posedge I_RST)
      begin
        if (I_RST)
          hist <= '{default: 8'h00};
        else if (srst)
          hist <= '{default: 8'h00};
        else if (acc)
          hist <= '{adiff, hist[0], hist[1], hist[2]};
      end
    end
  endgenerate

  // Output buffer absorbs downstream stalls; its level throttles the inputs
  assign fifo_in = {I_CUR_SOF, I_CUR_LAST, motion, blend};
  assign fifo_pop = fifo_valid && (!O_OUT_VALID || I_OUT_READY);
  rtdn_fifo #(.WIDTH(FW), .DEPTH(OUT_FIFO_DEPTH)) u_out_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst(I_RST),
    .i_clr(srst),
    .i_valid(acc),
    .o_ready(fifo_in_ready),
    .i_data(fifo_in),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_out),
    .o_level(fifo_level)
  );

  // Registered output stage feeding both frame store and downstream
  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_OUT_VALID <= 1'b0;
      {O_OUT_SOF, O_OUT_LAST, O_OUT_MOTION, O_OUT_DATA} <= '0;
    end
    else if (srst)
    begin
      O_OUT_VALID <= 1'b0;
      {O_OUT_SOF, O_OUT_LAST, O_OUT_MOTION, O_OUT_DATA} <= '0;
    end
    else if (fifo_pop)
    begin
      O_OUT_VALID <= 1'b1;
      {O_OUT_SOF, O_OUT_LAST, O_OUT_MOTION, O_OUT_DATA} <= fifo_out;
    end
    else if (I_OUT_READY)
      O_OUT_VALID <= 1'b0;
  end

  // Checks
  sequence s_load_last;
    wr_fire && I_S_AXI_AWADDR == OFS_CURVE_DATA && load_idx == 8'd127 && !srst;
  endsequence
  property p_load_flag;
    @(posedge I_CLK_SYS) disable iff (I_RST) s_load_last |=> flags[0] ##1 flags[0] || srst;
  endproperty
  a_load_flag: assert property (p_load_flag) else $error("load flag missing");
  property p_irq;
    @(posedge I_CLK_SYS) disable iff (I_RST) (|(flags & mask)) |=> O_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  // Other direction, so a stuck-high pin is caught too
  property p_irq_low;
    @(posedge I_CLK_SYS) disable iff (I_RST) !(|(flags & mask)) |=> !O_IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq raised without cause");
  property p_bypass;
    @(posedge I_CLK_SYS) disable iff (I_RST) acc && ctrl[2] |-> blend == I_CUR_DATA;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered pixel");
  property p_srst;
    @(posedge I_CLK_SYS) disable iff (I_RST) srst |=> !O_OUT_VALID && flags == 0
      && !O_CUR_READY;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset not holding");
  property p_sticky;
    @(posedge I_CLK_SYS) disable iff (I_RST) flags[0] && !srst
      && !(wr_fire && I_S_AXI_AWADDR == OFS_EVENT_FLAGS) |=> flags[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_w1c;
    @(posedge I_CLK_SYS) disable iff (I_RST) wr_fire && I_S_AXI_AWADDR == OFS_EVENT_FLAGS
      && I_S_AXI_WDATA[0] && I_S_AXI_WSTRB[0] && !load_done && !srst |=> !flags[0];
  endproperty
  a_w1c: assert property (p_w1c) else $error("flag not cleared");
  property p_restart;
    @(posedge I_CLK_SYS) disable iff (I_RST) wr_fire && I_S_AXI_AWADDR == OFS_BANK_TARGET
      |=> load_idx == 0;
  endproperty
  a_restart: assert property (p_restart) else $error("load not restarted");
  property p_sof_err;
    @(posedge I_CLK_SYS) disable iff (I_RST) acc && I_CUR_SOF && !at_sof_pos && !srst
      |=> O_EVENT_VEC[2] ##1 !O_EVENT_VEC[2] || $past(acc);
  endproperty
  a_sof_err: assert property (p_sof_err) else $error("sof error wrong");
  property p_commit;
    @(posedge I_CLK_SYS) disable iff (I_RST) frame_end && ctrl[1] && !srst
      |=> dim_act == $past(dim_pend) && bank_act == $past(bank_pend);
  endproperty
  a_commit: assert property (p_commit) else $error("commit missed");
  property p_halt;
    @(posedge I_CLK_SYS) disable iff (I_RST) !ctrl[0] |=> !O_CUR_READY && !O_PREV_READY;
  endproperty
  a_halt: assert property (p_halt) else $error("video not halted");
endmodule

// ### test/rtdn_video_partner.sv
// Stream partner: current and previous frame sources plus output sink
`timescale 1ns/10ps
module rtdn_video_partner (
  input wire logic i_clk,
  input wire logic i_ready,
  output logic [15:0] o_cur,
  output logic [15:0] o_prev,
  output logic o_valid,
  output logic o_last,
  output logic o_sof,
  output logic o_sink_ready
);
  logic stall = 1'h0;
  // Idle lines at time zero
  initial
  begin
    o_valid = 1'h0;
    o_last = 1'h0;
    o_sof = 1'h0;
    o_cur = 16'h0000;
    o_prev = 16'h0000;
  end
  // Sink refuses every other cycle, so the output buffer must hold beats
  always @(posedge i_clk) stall <= ~stall;
  assign o_sink_ready = ~stall;
  // One beat on both streams at once, held until the accepting edge
  task automatic send(input logic [15:0] c, input logic [15:0] p, input logic l, input logic s);
    o_cur <= c;
    o_prev <= p;
    o_last <= l;
    o_sof <= s;
    o_valid <= 1'h1;
    do @(posedge i_clk); while (i_ready !== 1'h1);
    o_valid <= 1'h0;
    o_last <= 1'h0;
    o_sof <= 1'h0;
    // Released data must not look like a still-valid pixel
    o_cur <= ~c;
    o_prev <= ~p;
    // Let an edge pass, so a following beat is not set in the same step
    @(posedge i_clk);
  endtask
endmodule

// ### test/testbench.sv
// Self-checking bench for the temporal denoise core
`timescale 1ns/10ps
module testbench;
  import rtdn_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_W-1:0] aw = '0;
  logic [ADDR_W-1:0] ar = '0;
  logic [DATA_W-1:0] wd = '0;
  logic [DATA_W-1:0] rdat;
  logic awv = 1'h0;
  logic arv = 1'h0;
  logic awr, wrr, bv, arr, rv, irq, v, l, s, rdy, prdy, ov, ordy, os, ol;
  logic [1:0] br, rr;
  logic [PIX_W-1:0] c, p, od, om;
  logic [7:0] ev;
  logic [7:0] ev_seen = 8'h00;
  logic [33:0] expq[$];
  int nbeat = 0;
  int err_total = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  // Build-time picture 64x32; software may program any size that fits 13 bits per dimension
  rtdn_core #(.DEF_PIXELS(13'h040), .DEF_LINES(13'h020)) dut (
    .I_CLK_SYS(clk), .I_RST(rst), .I_S_AXI_AWADDR(aw), .I_S_AXI_AWVALID(awv),
    .O_S_AXI_AWREADY(awr), .I_S_AXI_WDATA(wd), .I_S_AXI_WSTRB(4'hF), .I_S_AXI_WVALID(awv),
    .O_S_AXI_WREADY(wrr), .O_S_AXI_BRESP(br), .O_S_AXI_BVALID(bv), .I_S_AXI_BREADY(1'h1),
    .I_S_AXI_ARADDR(ar), .I_S_AXI_ARVALID(arv), .O_S_AXI_ARREADY(arr),
    .O_S_AXI_RDATA(rdat), .O_S_AXI_RRESP(rr), .O_S_AXI_RVALID(rv), .I_S_AXI_RREADY(1'h1),
    .I_CUR_DATA(c), .I_CUR_VALID(v), .I_CUR_LAST(l), .I_CUR_SOF(s), .O_CUR_READY(rdy),
    .I_PREV_DATA(p), .I_PREV_VALID(v), .I_PREV_LAST(l), .I_PREV_SOF(s), .O_PREV_READY(prdy),
    .O_OUT_DATA(od), .O_OUT_MOTION(om), .O_OUT_LAST(ol), .O_OUT_SOF(os), .O_OUT_VALID(ov),
    .I_OUT_READY(ordy), .O_IRQ(irq), .O_EVENT_VEC(ev));
  // Both readies must be up, or the beat is never taken and the watchdog fires
  rtdn_video_partner vp (.i_clk(clk), .i_ready(rdy & prdy), .o_cur(c), .o_prev(p),
    .o_valid(v), .o_last(l), .o_sof(s), .o_sink_ready(ordy));
  // Compare and count
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Write: address and data held together until the ready edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'h1;
    do @(posedge clk); while (awr !== 1'h1 || wrr !== 1'h1);
    awv <= 1'h0;
    do @(posedge clk); while (bv !== 1'h1);
    chk(br, 32'h0);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    ar <= a;
    arv <= 1'h1;
    do @(posedge clk); while (arr !== 1'h1);
    arv <= 1'h0;
    do @(posedge clk); while (rv !== 1'h1);
    chk(rdat, e);
    chk(rr, 32'h0);
  endtask
  // Expected beat queued before it leaves the source; motion grows as taps fill
  task automatic px(input logic lst, input logic sf, input logic [15:0] e);
    logic [7:0] ml;
    logic [7:0] mc;
    ml = (nbeat == 0) ? 8'h08 : (nbeat == 1) ? 8'h18 : 8'h20;
    mc = (nbeat < 2) ? 8'h10 : (nbeat < 4) ? 8'h30 : 8'h40;
    nbeat++;
    expq.push_back({sf, lst, mc, ml, e});
    vp.send(16'h8010, 16'h4030, lst, sf);
  endtask
  // Gather event pulses; check markers, motion and pixel of each delivered beat
  always @(posedge clk)
  begin
    ev_seen <= ev_seen | ev;
    if (ov === 1'h1 && ordy === 1'h1)
      chk({os, ol, om, od}, expq.pop_front());
  end
  // Cut a hang short; the full run needs under eight thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out;
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(OFS_CONTROL, 32'h0000_0000);
    wr(OFS_REVISION, 32'h0000_0000);
    rd(OFS_REVISION, CORE_REVISION);
    rd(9'h008, 32'h0000_0000);
    wr(OFS_PIC_DIM, 32'h0020_0020);
    rd(OFS_PIC_DIM, 32'h0020_0020);
    // A cut load of zeros leaves the flag low; a restart must overwrite them
    wr(OFS_BANK_TARGET, 32'h0000_0000);
    for (int i = 0; i < 12; i++)
      wr(OFS_CURVE_DATA, 32'h0000_0000);
    rd(OFS_EVENT_FLAGS, 32'h0000_0000);
    wr(OFS_BANK_TARGET, 32'h0000_0000);
    for (int i = 0; i < CURVE_LEN; i++)
      wr(OFS_CURVE_DATA, 32'h0000_0080);
    rd(OFS_EVENT_FLAGS, 32'h0000_0001);
    chk(irq, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    @(posedge clk);
    chk(irq, 32'h1);
    wr(OFS_EVENT_FLAGS, 32'h0000_0000);
    rd(OFS_EVENT_FLAGS, 32'h0000_0001);
    wr(OFS_EVENT_FLAGS, 32'h0000_0001);
    rd(OFS_EVENT_FLAGS, 32'h0000_0000);
    chk(irq, 32'h0);
    // A 64x32 frame, bypassed at first; its end commits the 32-wide size
    wr(OFS_CONTROL, 32'h0000_0005);
    for (int i = 0; i < 2048; i++)
    begin
      if (i == 16)
        wr(OFS_CONTROL, 32'h0000_0003);
      px(i % 64 == 63, i == 0, i < 16 ? 16'h8010 : 16'h6020);
    end
    // A last marker on pixel 31 is legal only once the new width is in use
    for (int i = 0; i < 32; i++)
      px(i == 31, 1'h0, 16'h6020);
    repeat (2) @(posedge clk);
    chk(ev_seen, 32'h00);
    px(1'h1, 1'h0, 16'h6020);
    repeat (2) @(posedge clk);
    chk(ev_seen, 32'h11);
    chk(ev, 32'h00);
    px(1'h0, 1'h1, 16'h6020);
    repeat (2) @(posedge clk);
    chk(ev_seen, 32'h55);
    repeat (4) @(posedge clk);
    chk(expq.size(), 32'h0);
    wr(OFS_CONTROL, 32'h8000_0001);
    rd(OFS_IRQ_MASK, 32'h0000_0000);
    rd(OFS_PIC_DIM, 32'h0020_0040);
    wr(OFS_CONTROL, 32'h0000_0000);
    close_out;
  end
endmodule
